// *** hw/wws_pkg.sv ***
package wws_pkg;

  // core clock rate and the width of every window counter
  localparam longint unsigned CLK_HZ      = 64'd25_000_000;
  localparam int              CNT_W       = 32;

  // fixed window timeouts, in milliseconds as printed
  localparam longint unsigned TIMEOUT_SHORT_MS = 64'd250;
  localparam longint unsigned TIMEOUT_LONG_MS  = 64'd2500;
  // capacitor timeout base term, in microseconds (6.25 ms with no capacitor)
  localparam longint unsigned CAP_BASE_US      = 64'd6250;
  // length of the reset pulse that a violation produces, in microseconds
  localparam longint unsigned RESET_HOLD_US    = 64'd1000;

  // cycle counts derived from the times above; a longest time rounds down
  localparam longint unsigned TIMEOUT_SHORT_CYC = TIMEOUT_SHORT_MS * CLK_HZ / 64'd1000;
  localparam longint unsigned TIMEOUT_LONG_CYC  = TIMEOUT_LONG_MS * CLK_HZ / 64'd1000;
  localparam longint unsigned CAP_BASE_CYC      = CAP_BASE_US * CLK_HZ / 64'd1000000;
  // a least time rounds up
  localparam longint unsigned RESET_HOLD_CYC    = (RESET_HOLD_US * CLK_HZ + 64'd999999) / 64'd1000000;

  // lower-boundary ratios, scaled by ten to keep the printed decimal
  localparam longint unsigned RATIO_WIDE_LOW    = 64'd1249;
  localparam longint unsigned RATIO_WIDE_HIGH   = 64'd1277;
  localparam longint unsigned RATIO_WIDE_CAP    = 64'd645;
  localparam longint unsigned RATIO_NARROW_LOW  = 64'd318;
  localparam longint unsigned RATIO_NARROW_HIGH = 64'd320;
  localparam longint unsigned RATIO_NARROW_CAP  = 64'd258;
  localparam longint unsigned RATIO_SCALE       = 64'd10;

  // timeout strap encoding: tied low, tied high, or capacitor sensed
  localparam logic [1:0] TSEL_LOW  = 2'h0;
  localparam logic [1:0] TSEL_HIGH = 2'h1;
  localparam logic [1:0] TSEL_CAP  = 2'h2;

  // edges the straps need to cross the two-flop synchroniser before they may be latched
  localparam logic [1:0] STRAP_SYNC_CYC = 2'h2;

  // watchdog sequencing states
  typedef enum logic [1:0] {
    ST_CFG,
    ST_RUN,
    ST_HOLD
  } wws_state_t;

  // decoded window, in core cycles
  typedef struct packed {
    logic [CNT_W-1:0] timeout;   // upper bound of the window
    logic [CNT_W-1:0] lower;     // lower boundary of the window
  } wws_cfg_t;

  // ratio (scaled by ten) picked by the two straps
  function automatic longint unsigned wws_ratio(input logic [1:0] tsel, input logic rsel);
    longint unsigned r;
    r = 64'd0;
    case (tsel)
      TSEL_LOW: r = rsel ? RATIO_WIDE_LOW  : RATIO_NARROW_LOW;
      TSEL_HIGH: r = rsel ? RATIO_WIDE_HIGH : RATIO_NARROW_HIGH;
      default: r = rsel ? RATIO_WIDE_CAP  : RATIO_NARROW_CAP;
    endcase
    return r;
  endfunction : wws_ratio

  // lower boundary = timeout / ratio, truncated to whole cycles
  function automatic logic [CNT_W-1:0] wws_lower(input logic [CNT_W-1:0] tmo,
                                                 input logic [1:0] tsel, input logic rsel);
    longint unsigned l;
    l = 64'(tmo) * RATIO_SCALE / wws_ratio(tsel, rsel);
    return l[CNT_W-1:0];
  endfunction : wws_lower

endpackage : wws_pkg

// *** hw/wws_sync_edge.sv ***
`timescale 1ns/1ps
// two-stage synchroniser for asynchronous pins with a rising-edge pulse per bit
module wws_sync_edge #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise
);

  logic [W-1:0] meta_q;   // first stage, read only by the second
  logic [W-1:0] sync_q;   // second stage, safe to use
  logic [W-1:0] prev_q;   // delayed copy for edge detection
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_d;
  logic [W-1:0] prev_d;

  // next values: plain shift chain
  always_comb begin
    meta_d = pinIn;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  // registers clear to zero, so a pin already high at release is seen as an edge once it reaches the second stage
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  assign level = sync_q;
  assign rise  = sync_q & ~prev_q;

endmodule : wws_sync_edge

// *** hw/wws_top.sv ***
`timescale 1ns/1ps
// Operation
// - two straps choose timeout and lower ratio
// - lower boundary is timeout divided by ratio
// - ratio strap high: 124.9, 127.7, 64.5
// - ratio strap low: 31.8, 32, 25.8
// - timeouts 0.25 s, 2.5 s, or capacitor
// - reset on timeout or on early trigger
// - each good trigger rise restarts window, clears timers
// - lower check off until first trigger rise
// - trigger rise acted on at third clock edge after the pin rises
module wws_top #(
  parameter longint unsigned TIMEOUT_SHORT = wws_pkg::TIMEOUT_SHORT_CYC,  // 0.25 s window
  parameter longint unsigned TIMEOUT_LONG  = wws_pkg::TIMEOUT_LONG_CYC,   // 2.5 s window
  parameter longint unsigned TIMEOUT_CAP   = wws_pkg::CAP_BASE_CYC,       // window set by capacitor
  parameter longint unsigned RESET_HOLD    = wws_pkg::RESET_HOLD_CYC      // reset pulse length
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       trigger_input,
  input  wire logic [1:0] timeout_select,
  input  wire logic       window_ratio_select,
  output logic            resetOut_n,
  output logic            resetOe_n
);

  localparam logic [wws_pkg::CNT_W-1:0] HOLD_LAST = wws_pkg::CNT_W'(RESET_HOLD - 64'd1);

  // synchronised pins; only the trigger needs an edge, the straps only a level
  logic       trigRise;     // one-cycle pulse per trigger rise
  logic [1:0] tselSync;     // timeout strap after two flops
  logic       rselSync;     // ratio strap after two flops
  logic [2:0] strapLevel;   // bit 2 ratio strap, bits 1:0 timeout strap

  // trigger crosses in from the pin through two flops; its level is of no use here
  wws_sync_edge #(.W(1)) u_sync_trig (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pinIn   (trigger_input),
    .level   (),
    .rise    (trigRise)
  );

  // straps take the same two flops; a strap edge means nothing, so rise is left open
  wws_sync_edge #(.W(3)) u_sync_strap (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pinIn   ({window_ratio_select, timeout_select}),
    .level   (strapLevel),
    .rise    ()
  );

  assign tselSync = strapLevel[1:0];
  assign rselSync = strapLevel[2];

  wws_pkg::wws_state_t            state_q;     // sequencing state
  wws_pkg::wws_state_t            state_d;
  wws_pkg::wws_cfg_t              cfg_q;       // window latched after reset
  wws_pkg::wws_cfg_t              cfg_d;
  logic [wws_pkg::CNT_W-1:0]      cnt_q;       // window or hold counter
  logic [wws_pkg::CNT_W-1:0]      cnt_d;
  logic                           lowerEn_q;   // lower-boundary check armed
  logic                           lowerEn_d;
  logic                           resetOut_n_q; // reset output level, low = asserted
  logic                           resetOut_n_d;
  logic [1:0]                     decodeWait_q; // edges left until the strap sync has settled
  logic [1:0]                     decodeWait_d;
  logic [wws_pkg::CNT_W-1:0]      tmoSel;      // timeout chosen by the strap

  // timeout per strap; any code other than low/high counts as capacitor
  always_comb begin
    case (tselSync)
      wws_pkg::TSEL_LOW:  tmoSel = wws_pkg::CNT_W'(TIMEOUT_SHORT);
      wws_pkg::TSEL_HIGH: tmoSel = wws_pkg::CNT_W'(TIMEOUT_LONG);
      default:            tmoSel = wws_pkg::CNT_W'(TIMEOUT_CAP);
    endcase
  end

  // next-state logic for the whole watchdog
  always_comb begin
    state_d      = state_q;
    cfg_d        = cfg_q;
    cnt_d        = cnt_q;
    lowerEn_d    = lowerEn_q;
    resetOut_n_d = resetOut_n_q;
    decodeWait_d = decodeWait_q;
    case (state_q)
      wws_pkg::ST_CFG: begin
        // straps need two cycles to pass the synchroniser before they are trusted
        // the sync flops clear to zero, so latching any earlier would read a false low strap
        if (decodeWait_q != 2'h0) begin
          decodeWait_d = decodeWait_q - 2'h1;
        end else begin
          cfg_d.timeout = tmoSel;
          cfg_d.lower   = wws_pkg::wws_lower(tmoSel, tselSync, rselSync);
          cnt_d         = '0;
          lowerEn_d     = 1'b0;
          resetOut_n_d  = 1'b1;
          state_d       = wws_pkg::ST_RUN;
        end
      end
      wws_pkg::ST_RUN: begin
        if (trigRise) begin
          if (lowerEn_q && (cnt_q < cfg_q.lower)) begin
            // trigger inside the lower boundary: early violation
            state_d      = wws_pkg::ST_HOLD;
            cnt_d        = '0;
            resetOut_n_d = 1'b0;
          end else begin
            // good trigger: new window, timers cleared, lower check armed
            cnt_d     = '0;
            lowerEn_d = 1'b1;
          end
        end else if (cnt_q >= cfg_q.timeout - 1'b1) begin
          // no trigger before the timeout expired
          state_d      = wws_pkg::ST_HOLD;
          cnt_d        = '0;
          resetOut_n_d = 1'b0;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      wws_pkg::ST_HOLD: begin
        // triggers are ignored while the reset pulse stands
        if (cnt_q == HOLD_LAST) begin
          state_d      = wws_pkg::ST_RUN;
          cnt_d        = '0;
          lowerEn_d    = 1'b0;
          resetOut_n_d = 1'b1;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      default: begin
        state_d = wws_pkg::ST_CFG;
      end
    endcase
  end

  // state registers; the supply-monitor reset holds the output asserted
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q      <= wws_pkg::ST_CFG;
      cfg_q        <= '0;
      cnt_q        <= '0;
      lowerEn_q    <= 1'b0;
      resetOut_n_q <= 1'b0;
      decodeWait_q <= wws_pkg::STRAP_SYNC_CYC;
    end else begin
      state_q      <= state_d;
      cfg_q        <= cfg_d;
      cnt_q        <= cnt_d;
      lowerEn_q    <= lowerEn_d;
      resetOut_n_q <= resetOut_n_d;
      decodeWait_q <= decodeWait_d;
    end
  end

  // open drain: the enable is low exactly while the pin is pulled low
  assign resetOut_n = resetOut_n_q;
  assign resetOe_n  = resetOut_n_q;

  // hold counter only an assertion reads
  logic [wws_pkg::CNT_W-1:0] lowRun_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lowRun_q <= '0;
    end else begin
      lowRun_q <= resetOut_n_q ? '0 : lowRun_q + 1'b1;
    end
  end

  chk_timeout_fires: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_q == wws_pkg::ST_RUN && !trigRise && cnt_q == cfg_q.timeout - 1'b1)
      |=> (state_q == wws_pkg::ST_HOLD && !resetOut_n && cnt_q == '0))
    else $error("timeout did not raise reset");

  chk_early_fires: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_q == wws_pkg::ST_RUN && trigRise && lowerEn_q && cnt_q < cfg_q.lower)
      |=> !resetOut_n ##1 !resetOut_n)
    else $error("early trigger did not raise reset");

  chk_good_restart: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_q == wws_pkg::ST_RUN && trigRise && (!lowerEn_q || cnt_q >= cfg_q.lower))
      |=> (cnt_q == '0 && lowerEn_q && resetOut_n && state_q == wws_pkg::ST_RUN))
    else $error("valid trigger did not restart window");

  // every window that follows a reset opens with the lower check off
  chk_first_window_open: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(resetOut_n) |-> !lowerEn_q)
    else $error("lower check armed at start of window");

  // the lower check is armed only by a trigger rise seen while running
  chk_arm_after_rise: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(lowerEn_q) |-> ($past(trigRise) && $past(state_q) == wws_pkg::ST_RUN))
    else $error("lower check armed without a trigger");

  chk_cfg_static: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_q != wws_pkg::ST_CFG && $past(state_q) != wws_pkg::ST_CFG) |-> $stable(cfg_q))
    else $error("window changed after decode");

  chk_lower_below: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_q == wws_pkg::ST_RUN) |-> (cfg_q.lower < cfg_q.timeout && cnt_q < cfg_q.timeout))
    else $error("window bounds out of order");

  chk_oe_tracks: assert property (@(posedge clk_sys) disable iff (!rst_n)
    resetOe_n == resetOut_n)
    else $error("reset enable differs from level");

  chk_hold_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ($rose(resetOut_n) && $past(state_q) == wws_pkg::ST_HOLD) |-> lowRun_q == HOLD_LAST + 1'b1)
    else $error("reset pulse has wrong length");

  chk_trig_seen: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_q == wws_pkg::ST_RUN && trigRise) |=> (cnt_q == '0 || !resetOut_n))
    else $error("trigger edge not acted on next cycle");

endmodule : wws_top

// *** verif/window_watchdog_supervisor_tb.sv ***
`timescale 1ns/1ps
// bench: every strap code through first-window, good, early and late triggers
module window_watchdog_supervisor_tb;
  localparam longint unsigned T_SHORT = 64'hFA0;   // shortened 0.25 s window
  localparam longint unsigned T_LONG  = 64'h1F40;  // shortened 2.5 s window
  localparam longint unsigned T_CAP   = 64'h7D0;   // shortened capacitor window
  localparam longint unsigned HOLD    = 64'h8;     // shortened reset pulse

  logic        clk_sys;              // core clock
  logic        rst_n;                // supervisor reset
  logic        trigger_input;        // trigger pin from the processor model
  logic [1:0]  timeout_select;       // timeout strap
  logic        window_ratio_select;  // ratio strap
  logic        resetOut_n;           // reset output level
  logic        resetOe_n;            // reset pin enable, low while pulling
  logic        go;                   // request to the processor model
  logic [31:0] gap;                  // cycles until the next rise
  int          fail_count;           // mismatches
  int          checks;               // comparisons

  wws_top #(.TIMEOUT_SHORT(T_SHORT), .TIMEOUT_LONG(T_LONG), .TIMEOUT_CAP(T_CAP), .RESET_HOLD(HOLD)) dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .trigger_input(trigger_input), .timeout_select(timeout_select),
    .window_ratio_select(window_ratio_select), .resetOut_n(resetOut_n), .resetOe_n(resetOe_n));
  wws_cpu_model cpu_u (.clk_sys(clk_sys), .go(go), .gap(gap), .trigger_input(trigger_input));

  // 25 MHz
  always #20 clk_sys = ~clk_sys;

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // verdict and stop
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim

  // request a rise g cycles ahead, then count cycles until reset falls or lim runs out
  task automatic pulse(input int g, input int lim, output int cyc);
    gap = g;
    go = 1'b1;
    @(posedge clk_sys);
    #1 go = 1'b0;
    cyc = 0;
    while (resetOut_n !== 1'b0 && cyc < lim) begin
      @(posedge clk_sys);
      #1 cyc++;
    end
  endtask : pulse

  // expected timeout in cycles; codes 2 and 3 both mean capacitor
  function automatic int exp_tmo(input logic [1:0] ts);
    return ts == 2'h0 ? int'(T_SHORT) : ts == 2'h1 ? int'(T_LONG) : int'(T_CAP);
  endfunction : exp_tmo

  // expected lower boundary: timeout over the ratio, truncated
  function automatic int exp_low(input logic [1:0] ts, input logic rs);
    longint unsigned r;
    if (ts == 2'h0) r = rs ? wws_pkg::RATIO_WIDE_LOW : wws_pkg::RATIO_NARROW_LOW;
    else if (ts == 2'h1) r = rs ? wws_pkg::RATIO_WIDE_HIGH : wws_pkg::RATIO_NARROW_HIGH;
    else r = rs ? wws_pkg::RATIO_WIDE_CAP : wws_pkg::RATIO_NARROW_CAP;
    return int'(64'(exp_tmo(ts)) * wws_pkg::RATIO_SCALE / r);
  endfunction : exp_low

  // main sequence
  initial begin
    int cyc, t, lo, g, n;
    clk_sys = 1'b0;
    rst_n = 1'b0;
    go = 1'b0;
    gap = 32'h0;
    timeout_select = 2'h0;
    window_ratio_select = 1'b0;
    fail_count = 0;
    checks = 0;
    void'($urandom(32'hA76B));
    for (int c = 0; c < 8; c++) begin
      // straps settle while reset is held; from the second pass on, reset lands mid-hold, inside the pulse from the last timeout
      @(posedge clk_sys);
      #1 rst_n = 1'b0;
      timeout_select = 2'(c / 2);
      window_ratio_select = c[0];
      t = exp_tmo(timeout_select);
      lo = exp_low(timeout_select, window_ratio_select);
      repeat (5) @(posedge clk_sys);
      #1 check(resetOe_n, 1'b0);
      rst_n = 1'b1;
      // straps still crossing the synchroniser: output held low for two edges
      repeat (2) @(posedge clk_sys);
      #1 check(resetOut_n, 1'b0);
      repeat (2) @(posedge clk_sys);
      #1 check(resetOut_n, 1'b1);
      check(resetOe_n, 1'b1);
      // an early rise is allowed in the first window
      pulse(2, 10, cyc);
      check(cyc, 10);
      // later strap moves must not alter the latched window
      timeout_select = 2'($urandom);
      window_ratio_select = ~window_ratio_select;
      // back-to-back calls land a rise 8 + gap counts after the last restart: here lo or beyond
      g = lo - 8 + $urandom_range(lo, 0);
      pulse(g, g + 8, cyc);
      check(cyc, g + 8);
      // rise one count short of the lower boundary; reset falls three edges after the rise
      g = lo - 9;
      pulse(g, g + 8, cyc);
      check(cyc, g + 3);
      check(resetOe_n, 1'b0);
      n = 0;
      while (resetOut_n === 1'b0 && n < 100) begin
        @(posedge clk_sys);
        #1 n++;
      end
      check(n, 32'(HOLD));
      // lower check is off again after a watchdog reset
      pulse(2, 10, cyc);
      check(cyc, 10);
      // rise exactly on the lower boundary is good, then silence runs into the timeout
      pulse(lo - 8, t + lo + 40, cyc);
      check(cyc, t + lo - 5);
    end
    end_sim();
  end

  // hang guard: about twice the roughly 36k cycles the tests need, well inside the run budget
  initial begin
    #3000000;
    fail_count++;
    end_sim();
  end
endmodule : window_watchdog_supervisor_tb

// *** verif/wws_cpu_model.sv ***
`timescale 1ns/1ps
// supervised processor: one trigger pulse per request, a chosen number of cycles later
module wws_cpu_model (
  input  wire logic        clk_sys,       // core clock, used as the program's time base
  input  wire logic        go,            // request for one trigger pulse
  input  wire logic [31:0] gap,           // cycles from request to rising edge
  output logic             trigger_input  // push-pull trigger pin, idles low
);
  // one process owns the pin, so it idles low from time zero with a single driver
  initial begin
    trigger_input = 1'b0;
    forever begin
      @(posedge clk_sys iff go);
      repeat (gap) @(posedge clk_sys);                 // caller varies gap inside the window
      #1 trigger_input = 1'b1;                         // raised as its own program step
      repeat (3) @(posedge clk_sys);
      #1 trigger_input = 1'b0;                         // lowered from a later step
    end
  end
endmodule : wws_cpu_model
